// ### bks_pkg.sv
// package: constants, register map and types of the key-click and buzzer controller
`default_nettype none
package bks_pkg;

  // clock and time base
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned CLICK_TIME_MS = 200;
  localparam int unsigned CLICK_CYCLES = CLICK_TIME_MS * CLK_KHZ;
  localparam int unsigned BEEP_ON_MS = 500;
  localparam int unsigned BEEP_OFF_MS = 500;
  localparam int unsigned BEEP_ON_CYCLES = BEEP_ON_MS * CLK_KHZ;
  localparam int unsigned BEEP_OFF_CYCLES = BEEP_OFF_MS * CLK_KHZ;
  localparam int CNT_W = 32;

  // apb register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] BUZ_CMD_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] SCREEN_SEL_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] STARTUP_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] TABLE_ADDR = 8'h0C;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h10;

  // field positions
  localparam int CMD_CONT_BIT = 0;
  localparam int CMD_INTER_BIT = 1;
  localparam int CMD_STOP_BIT = 2;
  localparam int SCR_W = 8;
  localparam int SEL_BUSY_BIT = 8;
  localparam int TBL_REG_BIT = 8;
  localparam int TBL_ATTR_BIT = 9;
  localparam int TBL_INTER_BIT = 10;
  localparam int ST_CLICK_EN_BIT = 0;
  localparam int ST_MODE_LSB = 1;
  localparam int ST_PCLICK_BIT = 4;
  localparam int ST_PMODE_LSB = 5;
  localparam int ST_BUZ_BIT = 8;
  localparam int ST_NOTREG_BIT = 9;
  localparam int ST_ERR_BIT = 10;
  localparam int ST_SCRACT_BIT = 11;
  localparam int ST_HOSTACT_BIT = 12;

  // screen table entry: {intermittent, buzzer attribute, registered}
  localparam int ENT_W = 3;
  localparam int ENT_REG = 0;
  localparam int ENT_ATTR = 1;
  localparam int ENT_INTER = 2;
  localparam int SCR_DEPTH = 256;

  localparam logic [SCR_W-1:0] NO_STARTUP = 8'h00;
  localparam logic [SCR_W-1:0] DEFAULT_SCREEN = 8'h01;

  typedef enum logic [2:0] {
    MODE_ALWAYS = 3'b001,
    MODE_ERR_ONLY = 3'b010,
    MODE_OFF = 3'b100
  } bks_mode_type;

  typedef enum logic [2:0] {
    SCR_IDLE = 3'b001,
    SCR_LOOK = 3'b010,
    SCR_APPLY = 3'b100
  } bks_scr_state_type;

  localparam logic CLICK_EN_RESET = 1'b1;
  localparam bks_mode_type MODE_RESET = MODE_ALWAYS;

endpackage
`default_nettype wire

// ### bks_screen_mem.sv
// screen attribute table: one write port, one registered read port
`timescale 1ns/100ps
`default_nettype none
module bks_screen_mem (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic wr_en, // write strobe
  input wire logic [bks_pkg::SCR_W-1:0] wr_addr, // entry written
  input wire logic [bks_pkg::ENT_W-1:0] wr_data, // entry value
  input wire logic [bks_pkg::SCR_W-1:0] rd_addr, // entry read
  output logic [bks_pkg::ENT_W-1:0] rd_data // entry value, one cycle later
);

  typedef struct packed {
    logic [bks_pkg::SCR_DEPTH-1:0][bks_pkg::ENT_W-1:0] mem;
    logic [bks_pkg::ENT_W-1:0] rdata;
  } bks_mem_state_type;

  bks_mem_state_type state_reg;
  bks_mem_state_type state_next;

  always_comb begin
    state_next = state_reg;
    // read sees the old entry on a same-address write
    state_next.rdata = state_reg.mem[rd_addr];
    if (wr_en) begin
      state_next.mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data = state_reg.rdata;

endmodule
`default_nettype wire

// ### bks_sound_ctrl.sv
// key-click and buzzer controller with apb slave and screen selection
`timescale 1ns/100ps
`default_nettype none
module bks_sound_ctrl #(
  parameter int unsigned CLICK_CYCLES = bks_pkg::CLICK_CYCLES, // key click length
  parameter int unsigned BEEP_ON_CYCLES = bks_pkg::BEEP_ON_CYCLES, // intermittent on
  parameter int unsigned BEEP_OFF_CYCLES = bks_pkg::BEEP_OFF_CYCLES // intermittent off
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [bks_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic touch_press, // touch switch press pulse
  input wire logic touch_stop_attr, // pressed switch carries buzzer stop
  input wire logic key_sound_key, // menu key: key click setting
  input wire logic buzzer_sound_key, // menu key: buzzer setting
  input wire logic write_and_exit_key, // menu key: commit settings
  input wire logic quit_key, // menu key: drop settings
  input wire logic run_start, // pulse on entering run operation
  input wire logic error_in, // device error condition, level
  input wire logic maint_test, // maintenance buzzer check, level
  output logic buzzer_out, // buzzer drive
  output logic key_sound_out, // key click drive
  output logic not_registered_out // screen not registered indication
);

  typedef struct packed {
    logic click_en;
    bks_pkg::bks_mode_type mode;
    logic pend_click_en;
    bks_pkg::bks_mode_type pend_mode;
    logic [bks_pkg::CNT_W-1:0] click_cnt;
    logic key_sound;
    logic host_active;
    logic host_cont;
    logic host_inter;
    logic scr_active;
    logic scr_inter;
    logic err_active;
    logic err_prev;
    logic beep_on;
    logic [bks_pkg::CNT_W-1:0] beep_cnt;
    logic buzzer;
    bks_pkg::bks_scr_state_type scr_state;
    logic [bks_pkg::SCR_W-1:0] look_addr;
    logic [bks_pkg::SCR_W-1:0] cur_screen;
    logic [bks_pkg::SCR_W-1:0] startup;
    logic not_reg;
    logic [31:0] rdata;
    logic slverr;
  } bks_state_type;

  bks_state_type state_reg;
  bks_state_type state_next;

  logic [bks_pkg::ENT_W-1:0] ent;
  logic tbl_wr;
  logic setup_ph;
  logic access_ph;
  logic wr_ok;
  logic host_wr;
  logic host_stop;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign pready = access_ph;
  assign mapped = (paddr == bks_pkg::BUZ_CMD_ADDR) || (paddr == bks_pkg::SCREEN_SEL_ADDR) ||
                  (paddr == bks_pkg::STARTUP_ADDR) || (paddr == bks_pkg::TABLE_ADDR) ||
                  (paddr == bks_pkg::STATUS_ADDR);
  assign wr_ok = access_ph && pwrite && !state_reg.slverr;
  assign host_wr = wr_ok && (paddr == bks_pkg::BUZ_CMD_ADDR);
  assign host_stop = host_wr && pwdata[bks_pkg::CMD_STOP_BIT];
  assign tbl_wr = wr_ok && (paddr == bks_pkg::TABLE_ADDR);

  bks_screen_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(tbl_wr),
    .wr_addr(pwdata[bks_pkg::SCR_W-1:0]),
    .wr_data(pwdata[bks_pkg::TBL_INTER_BIT:bks_pkg::TBL_REG_BIT]),
    .rd_addr(state_reg.look_addr),
    .rd_data(ent)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic src_host, src_scr, src_err;
    logic want_cont, want_inter;
    logic stop_all, err_set, scr_set, req_go;
    logic [bks_pkg::SCR_W-1:0] req_scr;
    src_host = 1'b0;
    src_scr = 1'b0;
    src_err = 1'b0;
    want_cont = 1'b0;
    want_inter = 1'b0;
    stop_all = 1'b0;
    err_set = 1'b0;
    scr_set = 1'b0;
    req_scr = bks_pkg::DEFAULT_SCREEN;
    req_go = 1'b0;
    state_next = state_reg;

    // read data and error are captured in the setup cycle so prdata is a flop
    if (setup_ph) begin
      state_next.slverr = !mapped;
      state_next.rdata = 32'h00000000;
      if (!pwrite) begin
        unique case (paddr)
          bks_pkg::BUZ_CMD_ADDR: begin
            state_next.rdata[bks_pkg::CMD_CONT_BIT] = state_reg.host_cont;
            state_next.rdata[bks_pkg::CMD_INTER_BIT] = state_reg.host_inter;
            state_next.rdata[bks_pkg::CMD_STOP_BIT] = state_reg.host_active;
          end
          bks_pkg::SCREEN_SEL_ADDR: begin
            state_next.rdata[bks_pkg::SCR_W-1:0] = state_reg.cur_screen;
            state_next.rdata[bks_pkg::SEL_BUSY_BIT] = state_reg.scr_state != bks_pkg::SCR_IDLE;
          end
          bks_pkg::STARTUP_ADDR: begin
            state_next.rdata[bks_pkg::SCR_W-1:0] = state_reg.startup;
          end
          bks_pkg::STATUS_ADDR: begin
            state_next.rdata[bks_pkg::ST_CLICK_EN_BIT] = state_reg.click_en;
            state_next.rdata[bks_pkg::ST_MODE_LSB+:3] = state_reg.mode;
            state_next.rdata[bks_pkg::ST_PCLICK_BIT] = state_reg.pend_click_en;
            state_next.rdata[bks_pkg::ST_PMODE_LSB+:3] = state_reg.pend_mode;
            state_next.rdata[bks_pkg::ST_BUZ_BIT] = state_reg.buzzer;
            state_next.rdata[bks_pkg::ST_NOTREG_BIT] = state_reg.not_reg;
            state_next.rdata[bks_pkg::ST_ERR_BIT] = state_reg.err_active;
            state_next.rdata[bks_pkg::ST_SCRACT_BIT] = state_reg.scr_active;
            state_next.rdata[bks_pkg::ST_HOSTACT_BIT] = state_reg.host_active;
          end
          default: state_next.rdata = 32'h00000000;
        endcase
      end
    end

    if (wr_ok && (paddr == bks_pkg::STARTUP_ADDR)) begin
      state_next.startup = pwdata[bks_pkg::SCR_W-1:0];
    end
    if (wr_ok && (paddr == bks_pkg::STATUS_ADDR) && pwdata[bks_pkg::ST_NOTREG_BIT]) begin
      state_next.not_reg = 1'b0;
    end

    // menu settings: pending copy, committed or dropped
    if (key_sound_key) begin
      state_next.pend_click_en = !state_reg.pend_click_en;
    end
    if (buzzer_sound_key) begin
      unique case (state_reg.pend_mode)
        bks_pkg::MODE_ALWAYS: state_next.pend_mode = bks_pkg::MODE_ERR_ONLY;
        bks_pkg::MODE_ERR_ONLY: state_next.pend_mode = bks_pkg::MODE_OFF;
        bks_pkg::MODE_OFF: state_next.pend_mode = bks_pkg::MODE_ALWAYS;
        default: state_next.pend_mode = bks_pkg::MODE_ALWAYS;
      endcase
    end
    if (write_and_exit_key) begin
      state_next.click_en = state_next.pend_click_en;
      state_next.mode = state_next.pend_mode;
    end else if (quit_key) begin
      state_next.pend_click_en = state_reg.click_en;
      state_next.pend_mode = state_reg.mode;
    end

    // key click, a new press restarts the pulse
    if (touch_press && state_reg.click_en) begin
      state_next.click_cnt = bks_pkg::CNT_W'(CLICK_CYCLES - 1);
      state_next.key_sound = 1'b1;
    end else if (state_reg.click_cnt != '0) begin
      state_next.click_cnt = state_reg.click_cnt - 1'b1;
    end else begin
      state_next.key_sound = 1'b0;
    end

    // screen selection; a request while busy is dropped
    if (state_reg.scr_state == bks_pkg::SCR_IDLE) begin
      if (run_start) begin
        req_go = 1'b1;
        if (state_reg.startup == bks_pkg::NO_STARTUP) begin
          req_scr = bks_pkg::DEFAULT_SCREEN;
        end else begin
          req_scr = state_reg.startup;
        end
      end else if (wr_ok && (paddr == bks_pkg::SCREEN_SEL_ADDR)) begin
        req_go = 1'b1;
        req_scr = pwdata[bks_pkg::SCR_W-1:0];
      end
    end
    unique case (state_reg.scr_state)
      bks_pkg::SCR_IDLE: begin
        if (req_go) begin
          state_next.look_addr = req_scr;
          state_next.scr_state = bks_pkg::SCR_LOOK;
        end
      end
      bks_pkg::SCR_LOOK: begin
        state_next.scr_state = bks_pkg::SCR_APPLY;
      end
      bks_pkg::SCR_APPLY: begin
        state_next.scr_state = bks_pkg::SCR_IDLE;
        if (!ent[bks_pkg::ENT_REG]) begin
          err_set = 1'b1;
        end else begin
          state_next.cur_screen = state_reg.look_addr;
          if (ent[bks_pkg::ENT_ATTR]) begin
            scr_set = !host_wr;
            state_next.scr_inter = ent[bks_pkg::ENT_INTER];
          end else begin
            stop_all = 1'b1;
          end
        end
      end
      default: state_next.scr_state = bks_pkg::SCR_IDLE;
    endcase

    // buzzer sources: clears first, sets after them so a set wins
    state_next.err_prev = error_in;
    if (error_in && !state_reg.err_prev) begin
      err_set = 1'b1;
    end
    if (host_stop || (touch_press && touch_stop_attr)) begin
      stop_all = 1'b1;
    end
    if (stop_all) begin
      state_next.host_active = 1'b0;
      state_next.scr_active = 1'b0;
      state_next.err_active = 1'b0;
    end
    if (host_wr && !host_stop) begin
      state_next.host_cont = pwdata[bks_pkg::CMD_CONT_BIT];
      state_next.host_inter = pwdata[bks_pkg::CMD_INTER_BIT];
      state_next.host_active = pwdata[bks_pkg::CMD_CONT_BIT] || pwdata[bks_pkg::CMD_INTER_BIT];
    end
    if (scr_set) begin
      state_next.scr_active = 1'b1;
    end
    if (err_set) begin
      state_next.err_active = 1'b1;
      state_next.not_reg = state_reg.not_reg || (state_reg.scr_state == bks_pkg::SCR_APPLY &&
                           !ent[bks_pkg::ENT_REG]);
    end

    // mode gating; host pattern overrides screen pattern
    src_host = state_reg.host_active && (state_reg.mode == bks_pkg::MODE_ALWAYS);
    src_scr = state_reg.scr_active && (state_reg.mode == bks_pkg::MODE_ALWAYS);
    src_err = state_reg.err_active && (state_reg.mode != bks_pkg::MODE_OFF);
    want_cont = maint_test || src_err || (src_host && state_reg.host_cont) ||
                (!src_host && src_scr && !state_reg.scr_inter);
    want_inter = (src_host && state_reg.host_inter) || (!src_host && src_scr && state_reg.scr_inter);

    // intermittent timer restarts with the on phase whenever it is not needed
    if (!want_inter || want_cont) begin
      state_next.beep_on = 1'b1;
      state_next.beep_cnt = bks_pkg::CNT_W'(BEEP_ON_CYCLES - 1);
    end else if (state_reg.beep_cnt != '0) begin
      state_next.beep_cnt = state_reg.beep_cnt - 1'b1;
    end else begin
      state_next.beep_on = !state_reg.beep_on;
      if (state_reg.beep_on) begin
        state_next.beep_cnt = bks_pkg::CNT_W'(BEEP_OFF_CYCLES - 1);
      end else begin
        state_next.beep_cnt = bks_pkg::CNT_W'(BEEP_ON_CYCLES - 1);
      end
    end
    state_next.buzzer = want_cont || (want_inter && state_reg.beep_on);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.click_en <= bks_pkg::CLICK_EN_RESET;
      state_reg.pend_click_en <= bks_pkg::CLICK_EN_RESET;
      state_reg.mode <= bks_pkg::MODE_RESET;
      state_reg.pend_mode <= bks_pkg::MODE_RESET;
      state_reg.scr_state <= bks_pkg::SCR_IDLE;
      state_reg.beep_on <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.rdata;
  assign pslverr = access_ph && state_reg.slverr;
  assign buzzer_out = state_reg.buzzer;
  assign key_sound_out = state_reg.key_sound;
  assign not_registered_out = state_reg.not_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_CLICK_START: assert property (@(posedge pclk) disable iff (!presetn)
    touch_press && state_reg.click_en |=> key_sound_out [*2])
    else $error("key click did not start on press");
  AST_CLICK_SILENT: assert property (@(posedge pclk) disable iff (!presetn)
    !state_reg.click_en && !key_sound_out |=> !key_sound_out)
    else $error("key click sounded while disabled");
  AST_MODE_CYCLE: assert property (@(posedge pclk) disable iff (!presetn)
    buzzer_sound_key && !quit_key && state_reg.pend_mode == bks_pkg::MODE_OFF
    |=> state_reg.pend_mode == bks_pkg::MODE_ALWAYS)
    else $error("buzzer setting did not wrap to always");
  AST_OFF_SILENT: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.mode == bks_pkg::MODE_OFF && !maint_test |=> !buzzer_out)
    else $error("buzzer sounded in off mode");
  AST_ERR_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.mode == bks_pkg::MODE_ERR_ONLY && !maint_test && !state_reg.err_active
    |=> !buzzer_out)
    else $error("error-only mode sounded without error");
  AST_HOST_CONT: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.mode == bks_pkg::MODE_ALWAYS && state_reg.host_active && state_reg.host_cont
    |=> buzzer_out)
    else $error("continuous host buzzer not on");
  AST_TEST: assert property (@(posedge pclk) disable iff (!presetn)
    maint_test |=> buzzer_out)
    else $error("buzzer test did not sound");
  AST_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    host_stop |=> !state_reg.host_active && !state_reg.scr_active)
    else $error("host stop left a source active");
  AST_STARTUP: assert property (@(posedge pclk) disable iff (!presetn)
    run_start && state_reg.scr_state == bks_pkg::SCR_IDLE &&
    state_reg.startup == bks_pkg::NO_STARTUP
    |=> state_reg.look_addr == bks_pkg::DEFAULT_SCREEN ##2 state_reg.scr_state == bks_pkg::SCR_IDLE)
    else $error("startup did not fall back to screen 1");
  AST_NOTREG: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.scr_state == bks_pkg::SCR_APPLY && !ent[bks_pkg::ENT_REG]
    |=> not_registered_out && $stable(state_reg.cur_screen))
    else $error("unregistered screen not flagged");
  AST_QUIT: assert property (@(posedge pclk) disable iff (!presetn)
    quit_key && !write_and_exit_key |=> state_reg.pend_mode == $past(state_reg.mode))
    else $error("quit kept pending setting");

endmodule
`default_nettype wire

// ### bks_panel_model.sv
// panel and host side model: touch switch, menu keys, run entry, error and test levels
`timescale 1ns/100ps
`default_nettype none
module bks_panel_model (
  input wire logic pclk, // system clock
  output logic touch_press, // press pulse
  output logic touch_stop_attr, // stop attribute of the pressed switch
  output logic [3:0] menu, // click, buzzer, commit, quit keys
  output logic run_start, // run entry pulse
  output logic error_in, // error level
  output logic maint_test // buzzer check level
);
  initial begin
    touch_press = 1'b0;
    touch_stop_attr = 1'b1;
    menu = 4'h0;
    run_start = 1'b0;
    error_in = 1'b0;
    maint_test = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // attribute inverted once released, so a stale level cannot look valid
  task automatic press(input logic stop);
    @(posedge pclk);
    touch_press <= 1'b1;
    touch_stop_attr <= stop;
    @(posedge pclk);
    touch_press <= 1'b0;
    touch_stop_attr <= ~stop;
  endtask
  task automatic key(input int k);
    @(posedge pclk);
    menu <= 4'(1 << k);
    @(posedge pclk);
    menu <= 4'h0;
  endtask
  task automatic run();
    @(posedge pclk);
    run_start <= 1'b1;
    @(posedge pclk);
    run_start <= 1'b0;
  endtask
  task automatic levels(input logic e, input logic m);
    @(posedge pclk);
    error_in <= e;
    maint_test <= m;
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking bench: apb register access, panel stimulus and sound output checks
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic pclk = 1'b0;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr, tp, tsa, rs, err, mt, buz, ks, nreg;
  logic [3:0] menu;
  logic [31:0] rd;
  logic er;
  int num_errors;
  int n_tests;
  int cnt;
  always #2 pclk = ~pclk;
  bks_panel_model p (.pclk(pclk), .touch_press(tp), .touch_stop_attr(tsa), .menu(menu),
    .run_start(rs), .error_in(err), .maint_test(mt));
  bks_sound_ctrl #(.CLICK_CYCLES(20), .BEEP_ON_CYCLES(8), .BEEP_OFF_CYCLES(8))
    bks_sound_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .touch_press(tp), .touch_stop_attr(tsa), .key_sound_key(menu[0]),
    .buzzer_sound_key(menu[1]), .write_and_exit_key(menu[2]), .quit_key(menu[3]),
    .run_start(rs), .error_in(err), .maint_test(mt), .buzzer_out(buz), .key_sound_out(ks),
    .not_registered_out(nreg));
  ////////////////////////////////////////////////////////////////
  task automatic results();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rd & m, e);
  endtask
  // request, apply and output register all settle within four edges
  task automatic bz(input logic e);
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    cmp({31'h0, buz}, {31'h0, e});
  endtask
  task automatic count(input int n, input bit click);
    cnt = 0;
    repeat (n) begin
      @(negedge pclk);
      if ((click ? ks : buz) === 1'b1) cnt++;
    end
  endtask
  task automatic commit(input int k);
    p.key(k);
    p.key(2);
  endtask
  initial begin
    #100000;
    num_errors++;
    results();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    num_errors = 0;
    n_tests = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk(8'h10, 32'hFF, 32'h33);
    p.press(1'b0);
    count(30, 1'b1);
    cmp(cnt, 20);
    commit(0);
    p.press(1'b0);
    count(30, 1'b1);
    cmp(cnt, 0);
    p.key(0);
    p.key(3);
    chk(8'h10, 32'hFF, 32'h22);
    commit(0);
    wr(8'h00, 32'h1);
    bz(1'b1);
    wr(8'h00, 32'h4);
    bz(1'b0);
    wr(8'h00, 32'h2);
    count(32, 1'b0);
    cmp(cnt, 16);
    wr(8'h00, 32'h3);
    count(32, 1'b0);
    cmp(cnt, 32);
    p.press(1'b1);
    bz(1'b0);
    wr(8'h0C, 32'h305);
    wr(8'h04, 32'h5);
    bz(1'b1);
    wr(8'h0C, 32'h106);
    wr(8'h04, 32'h6);
    bz(1'b0);
    wr(8'h04, 32'h7);
    repeat (3) @(posedge pclk);
    cmp({31'h0, nreg}, 32'h1);
    chk(8'h10, 32'h200, 32'h200);
    chk(8'h04, 32'hFF, 32'h6);
    wr(8'h10, 32'h200);
    chk(8'h10, 32'h200, 32'h0);
    cmp({31'h0, nreg}, 32'h0);
    wr(8'h0C, 32'h101);
    chk(8'h08, 32'hFF, 32'h0);
    p.run();
    repeat (3) @(posedge pclk);
    chk(8'h04, 32'hFF, 32'h1);
    commit(1);
    chk(8'h10, 32'hE, 32'h4);
    wr(8'h00, 32'h1);
    bz(1'b0);
    wr(8'h04, 32'h5);
    bz(1'b0);
    p.levels(1'b1, 1'b0);
    bz(1'b1);
    p.levels(1'b0, 1'b0);
    wr(8'h00, 32'h4);
    bz(1'b0);
    commit(1);
    chk(8'h10, 32'hE, 32'h8);
    p.levels(1'b1, 1'b0);
    bz(1'b0);
    wr(8'h00, 32'h1);
    bz(1'b0);
    p.levels(1'b1, 1'b1);
    bz(1'b1);
    p.levels(1'b0, 1'b0);
    wr(8'h00, 32'h4);
    bz(1'b0);
    commit(1);
    chk(8'h10, 32'hE, 32'h2);
    chk(8'h20, 32'hFFFFFFFF, 32'h0);
    cmp({31'h0, er}, 32'h1);
    results();
  end
endmodule
`default_nettype wire
